// ==== src/feedback_pkg.sv ====
// Shared constants, register map and carriers of the velocity capture block
package feedback_pkg;

    // ------------------------------------------------------------
    // Clock and instruction cycle
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int TCY_NS = 80;
    localparam int Q_PHASES = TCY_NS * CLK_MHZ / 1000;
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q4 = 2'(Q_PHASES - 1);
    localparam int FILTER_SAMPLES = 3;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_FILTER = 8'h00;
    localparam logic [7:0] OFF_ENC = 8'h04;
    localparam logic [7:0] OFF_CAP1 = 8'h08;
    localparam logic [7:0] OFF_VELCAP = 8'h0c;
    localparam logic [7:0] OFF_TIMER = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;
    localparam logic [7:0] OFF_IRQEN = 8'h18;
    localparam logic [7:0] OFF_TBCTL = 8'h1c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FLT_TCLK_BIT = 6;
    localparam int FLT_B_BIT = 5;
    localparam int FLT_A_BIT = 4;
    localparam int FLT_IDX_BIT = 3;
    localparam int FLT_DIV_LSB = 0;
    localparam int ENC_VELDIS_BIT = 7;
    localparam int ENC_MODE_LSB = 2;
    localparam int ENC_DEC_LSB = 0;
    localparam int CAP_REN_BIT = 6;
    localparam int FLAG_VEL_BIT = 0;
    localparam int FLAG_POS_BIT = 1;
    localparam int FLAG_DIR_BIT = 2;
    localparam int TB_ON_BIT = 0;
    localparam int TB_SYNC_BIT = 1;
    localparam int TB_EXT_BIT = 2;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] FILTER_RST = 8'h00;
    localparam logic [7:0] ENC_RST = 8'h80;
    localparam logic [7:0] CAP1_RST = 8'h00;
    localparam logic [7:0] TBCTL_RST = 8'h00;
    localparam logic [15:0] TIMER_CLEAR = 16'h0000;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_X2_IDX = 3'h1;
    localparam logic [2:0] MODE_X2_PER = 3'h2;
    localparam logic [2:0] MODE_X4_IDX = 3'h5;
    localparam logic [2:0] MODE_X4_PER = 3'h6;
    localparam logic [2:0] MODE_X4_ALT = 3'h7;
    localparam logic [2:0] FLT_DIV_UNUSED = 3'h7;
    localparam logic [5:0] DEC_LAST [0:3] = '{6'h00, 6'h03, 6'h0f, 6'h3f};
    localparam logic [6:0] FLT_MASK [0:7] =
        '{7'h00, 7'h01, 7'h03, 7'h0f, 7'h1f, 7'h3f, 7'h7f, 7'h00};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

    // Bit order: 3 timer clock, 2 phase b, 1 phase a, 0 index
    typedef struct packed {
        logic ext_clk;
        logic phase_b;
        logic phase_a;
        logic index;
    } enc_pins_s;

endpackage : feedback_pkg

// ==== src/glitch_filter.sv ====
// Three-sample glitch filter with bypass for one input
`timescale 1ns/1ps
`default_nettype none
module glitch_filter
    import feedback_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sample_en,
    input wire logic enable,
    input wire logic raw_in,
    output logic filt_out
);
    logic [FILTER_SAMPLES-1:0] hist_q;
    logic level_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hist_q <= '0;
        end else if (sample_en) begin
            hist_q <= {hist_q[FILTER_SAMPLES-2:0], raw_in};
        end
    end

    // Level moves only once the same value was seen on three samples
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            level_q <= 1'b0;
        end else if (&hist_q) begin
            level_q <= 1'b1; // R13 R14
        end else if (~|hist_q) begin
            level_q <= 1'b0; // R13
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            filt_out <= 1'b0;
        end else begin
            filt_out <= enable ? level_q : raw_in; // R15 R19
        end
    end
endmodule : glitch_filter
`default_nettype wire

// ==== src/velocity_capture.sv ====
// Velocity capture path, input noise filters and shared flags
//
// Function
// R01: x2 modes give a velocity event per phase-A edge, x4 per A and B edge.
// R02: Velocity measuring runs only with disable bit low and an encoder mode set.
// R03: Decimation 00 passes every event, 01 passes one in four.
// R04: Decimation 10 passes one in sixteen, 11 one in sixty-four.
// R05: Each decimated pulse copies the time base and raises the velocity flag.
// R06: Software puts the time base into a synchronous mode before use.
// R07: Timer clear happens on the first Q1 after the capture pulse.
// R08: Reset enable bit 6 of capture control clears the timer on capture.
// R09: With reset enable low the timer runs on, captures still update.
// R10: Entering velocity mode leaves the timer count untouched.
// R11: Decimation setting is kept across leaving and re-entering velocity mode.
// R12: Four filters: index, phase A, phase B, timer external clock.
// R13: Filter output follows a level only after three equal samples.
// R14: Filter group delay is three instruction cycles.
// R15: Each filter has an enable; clear means raw input bypass.
// R16: Shared sample clock from instruction cycle, divider 1:1 to 1:128.
// R17: Filter control: bit6 timer clk, 5 B, 4 A, 3 index, 2-0 divider.
// R18: Every reset clears the filter control register.
// R19: Filter enables act the same in capture and encoder modes.
// R20: Three flags mean capture events or velocity, position and direction.
// R21: Velocity flag is written at the Q2 phase.
// R22: In sleep the timer stops; the postscaler still counts events.
// R23: Sleep capture sets the flag, wakes if enabled, loads buffer on wake.
`timescale 1ns/1ps
`default_nettype none
module velocity_capture
    import feedback_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire axi_req_s bus_req,
    output axi_rsp_s bus_rsp,
    input wire enc_pins_s pins_raw,
    input wire logic sleep_mode,
    input wire logic [2:0] capture_event_in,
    input wire logic position_event_in,
    input wire logic direction_change_in,
    output enc_pins_s pins_filt,
    output logic velocity_capture_pulse,
    output logic wake_request
);
    // ------------------------------------------------------------
    // Registers and internal state
    // ------------------------------------------------------------
    logic [6:0] noise_filter_control_q;
    logic [7:0] encoder_control_register_q;
    logic [7:0] capture_channel_one_control_q;
    logic [2:0] time_base_control_q;
    logic [15:0] velocity_capture_register_q;
    logic [15:0] velocity_time_base_q;
    logic [2:0] peripheral_flag_register_q;
    logic [2:0] irq_enable_q;
    logic [1:0] phase_q;
    logic [6:0] div_cnt_q;
    logic a_prev_q;
    logic b_prev_q;
    logic clk_prev_q;
    logic rst_pend_q;
    logic flag_pend_q;
    logic sleep_prev_q;
    logic sleep_cap_q;

    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    logic [2:0] enc_mode;
    logic [1:0] dec_sel;
    logic [2:0] flt_div;
    logic enc_on;
    logic x2_mode;
    logic x4_mode;
    logic vel_active;
    logic tcy_en;
    logic at_q1;
    logic at_q2;
    logic sample_en;
    logic vel_event;
    logic vel_pulse;
    logic tb_inc;
    logic wake_load;
    logic wr_go;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [3:0] raw_v;
    logic [3:0] en_v;
    logic [3:0] filt_v;

    assign enc_mode = encoder_control_register_q[ENC_MODE_LSB +: 3];
    assign dec_sel = encoder_control_register_q[ENC_DEC_LSB +: 2];
    assign flt_div = noise_filter_control_q[FLT_DIV_LSB +: 3];
    assign enc_on = (enc_mode != MODE_OFF);
    assign x2_mode = (enc_mode == MODE_X2_IDX) || (enc_mode == MODE_X2_PER);
    assign x4_mode = (enc_mode == MODE_X4_IDX) || (enc_mode == MODE_X4_PER)
        || (enc_mode == MODE_X4_ALT);
    assign vel_active = !encoder_control_register_q[ENC_VELDIS_BIT]
        && (x2_mode || x4_mode); // R02
    assign tcy_en = (phase_q == PH_Q4) && !sleep_mode;
    assign at_q1 = (phase_q == PH_Q1) && !sleep_mode;
    assign at_q2 = (phase_q == PH_Q2) && !sleep_mode;

    // ------------------------------------------------------------
    // Instruction cycle phases and filter sample clock
    // ------------------------------------------------------------
    // Phases hold while sleep_mode is high; core_clk itself keeps running
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            phase_q <= PH_Q1;
        end else if (!sleep_mode) begin
            phase_q <= (phase_q == PH_Q4) ? PH_Q1 : phase_q + 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_cnt_q <= '0;
        end else if (tcy_en) begin
            div_cnt_q <= div_cnt_q + 7'h01;
        end
    end

    // Unused divider code stops sampling, filters then hold their level
    assign sample_en = tcy_en && (flt_div != FLT_DIV_UNUSED)
        && ((div_cnt_q & FLT_MASK[flt_div]) == FLT_MASK[flt_div]); // R16

    // ------------------------------------------------------------
    // Noise filters
    // ------------------------------------------------------------
    assign raw_v = pins_raw;
    assign en_v = {noise_filter_control_q[FLT_TCLK_BIT],
                   noise_filter_control_q[FLT_B_BIT],
                   noise_filter_control_q[FLT_A_BIT],
                   noise_filter_control_q[FLT_IDX_BIT]}; // R17

    for (genvar i = 0; i < 4; i++) begin : g_filter // R12
        glitch_filter u_filter (
            .core_clk (core_clk),
            .sys_rst (sys_rst),
            .sample_en (sample_en),
            .enable (en_v[i]),
            .raw_in (raw_v[i]),
            .filt_out (filt_v[i])
        );
    end
    assign pins_filt = filt_v;

    // ------------------------------------------------------------
    // Velocity events and postscaler
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            a_prev_q <= 1'b0;
            b_prev_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end else begin
            a_prev_q <= pins_filt.phase_a;
            b_prev_q <= pins_filt.phase_b;
            clk_prev_q <= pins_filt.ext_clk;
        end
    end

    assign vel_event = vel_active && ((pins_filt.phase_a != a_prev_q)
        || (x4_mode && (pins_filt.phase_b != b_prev_q))); // R01

    // Counter clears while inactive; the select field itself is never
    // touched, so re-entering the mode resumes the old ratio
    velocity_postscaler u_post (
        .core_clk (core_clk),
        .sys_rst (sys_rst),
        .clear (!vel_active),
        .event_in (vel_event), // R22
        .sel (dec_sel), // R11
        .pulse (vel_pulse)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            velocity_capture_pulse <= 1'b0;
        end else begin
            velocity_capture_pulse <= vel_pulse;
        end
    end

    // ------------------------------------------------------------
    // Time base, capture and deferred clear
    // ------------------------------------------------------------
    // R06
    assign tb_inc = time_base_control_q[TB_ON_BIT] && !sleep_mode // R22
        && (time_base_control_q[TB_EXT_BIT]
            ? (pins_filt.ext_clk && !clk_prev_q) : tcy_en);

    // A pulse in the Q1 cycle itself waits for the next Q1
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rst_pend_q <= 1'b0;
        end else if (vel_pulse && !sleep_mode) begin
            rst_pend_q <= capture_channel_one_control_q[CAP_REN_BIT]; // R08 R09
        end else if (at_q1) begin
            rst_pend_q <= 1'b0;
        end
    end

    // Only writes, counting and capture clears touch the count
    always_ff @(posedge core_clk) begin // R10
        if (sys_rst) begin
            velocity_time_base_q <= TIMER_CLEAR;
        end else if (at_q1 && rst_pend_q) begin
            velocity_time_base_q <= TIMER_CLEAR; // R07 R08
        end else if (wr_go && aw_addr_q == OFF_TIMER) begin
            if (w_strb_q[0]) velocity_time_base_q[7:0] <= w_data_q[7:0];
            if (w_strb_q[1]) velocity_time_base_q[15:8] <= w_data_q[15:8];
        end else if (tb_inc) begin
            velocity_time_base_q <= velocity_time_base_q + 16'h0001; // R09
        end
    end

    assign wake_load = sleep_prev_q && !sleep_mode && sleep_cap_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            velocity_capture_register_q <= '0;
        end else if ((vel_pulse && !sleep_mode) || wake_load) begin
            velocity_capture_register_q <= velocity_time_base_q; // R05 R23
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sleep_prev_q <= 1'b0;
            sleep_cap_q <= 1'b0;
        end else begin
            sleep_prev_q <= sleep_mode;
            if (vel_pulse && sleep_mode) begin
                sleep_cap_q <= 1'b1; // R23
            end else if (wake_load) begin
                sleep_cap_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flag_pend_q <= 1'b0;
        end else if (vel_pulse && !sleep_mode) begin
            flag_pend_q <= 1'b1;
        end else if (at_q2) begin
            flag_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shared flags and wake
    // ------------------------------------------------------------
    always_comb begin
        if (enc_on) begin
            flag_set[FLAG_VEL_BIT] = (at_q2 && flag_pend_q) // R05 R21
                || (vel_pulse && sleep_mode); // R23
            flag_set[FLAG_POS_BIT] = position_event_in;
            flag_set[FLAG_DIR_BIT] = direction_change_in;
        end else begin
            flag_set = capture_event_in; // R20
        end
    end

    assign flag_clr = (wr_go && aw_addr_q == OFF_FLAGS && w_strb_q[0])
        ? w_data_q[2:0] : 3'h0;

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            peripheral_flag_register_q <= '0;
        end else begin
            peripheral_flag_register_q <=
                (peripheral_flag_register_q & ~flag_clr) | flag_set; // R20
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= sleep_mode
                && |(peripheral_flag_register_q & irq_enable_q); // R23
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            noise_filter_control_q <= FILTER_RST[6:0]; // R18
            encoder_control_register_q <= ENC_RST;
            capture_channel_one_control_q <= CAP1_RST;
            time_base_control_q <= TBCTL_RST[2:0];
            irq_enable_q <= '0;
        end else if (wr_go && w_strb_q[0]) begin
            unique case (aw_addr_q)
                OFF_FILTER: noise_filter_control_q <= w_data_q[6:0]; // R17
                OFF_ENC: encoder_control_register_q <= w_data_q[7:0];
                OFF_CAP1: capture_channel_one_control_q <=
                    w_data_q[7:0] & (8'h01 << CAP_REN_BIT);
                OFF_TBCTL: time_base_control_q <= w_data_q[2:0];
                OFF_IRQEN: irq_enable_q <= w_data_q[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign wr_go = !awready_q && !wready_q && !bvalid_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            awready_q <= 1'b1;
            aw_addr_q <= '0;
        end else if (bus_req.awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_addr_q <= bus_req.awaddr;
        end else if (wr_go) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wready_q <= 1'b1;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (bus_req.wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_data_q <= bus_req.wdata;
            w_strb_q <= bus_req.wstrb;
        end else if (wr_go) begin
            wready_q <= 1'b1;
        end
    end

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= OFF_TBCTL);
    endfunction : mapped

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_DECERR;
        end else if (bus_req.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    logic [31:0] rd_val;
    always_comb begin
        rd_val = '0;
        unique case (bus_req.araddr)
            OFF_FILTER: rd_val[6:0] = noise_filter_control_q;
            OFF_ENC: rd_val[7:0] = encoder_control_register_q;
            OFF_CAP1: rd_val[7:0] = capture_channel_one_control_q;
            OFF_VELCAP: rd_val[15:0] = velocity_capture_register_q;
            OFF_TIMER: rd_val[15:0] = velocity_time_base_q;
            OFF_FLAGS: rd_val[2:0] = peripheral_flag_register_q;
            OFF_IRQEN: rd_val[2:0] = irq_enable_q;
            OFF_TBCTL: rd_val[2:0] = time_base_control_q;
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (bus_req.arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= mapped(bus_req.araddr) ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid_q && bus_req.rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign bus_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
                       bresp: bresp_q, arready: arready_q, rvalid: rvalid_q,
                       rdata: rdata_q, rresp: rresp_q};
endmodule : velocity_capture
`default_nettype wire

// ==== src/velocity_postscaler.sv ====
// Velocity event decimator, 1:1 to 1:64
`timescale 1ns/1ps
`default_nettype none
module velocity_postscaler
    import feedback_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic event_in,
    input wire logic [1:0] sel,
    output logic pulse
);
    logic [5:0] cnt_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst || clear) begin
            cnt_q <= '0;
            pulse <= 1'b0;
        end else if (event_in) begin
            if (cnt_q >= DEC_LAST[sel]) begin
                cnt_q <= '0; // R03 R04
                pulse <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 6'h01;
                pulse <= 1'b0;
            end
        end else begin
            pulse <= 1'b0;
        end
    end
endmodule : velocity_postscaler
`default_nettype wire

// ==== tb/encoder_model.sv ====
// Quadrature encoder stand-in with a phase-A glitch input
`timescale 1ns/1ps
`default_nettype none
module encoder_model
    import feedback_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic step,
    input wire logic glitch_a,
    output enc_pins_s pins
);
    // ----
    // Position
    // ----
    logic [1:0] pos_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pos_q <= 2'h0;
        end else if (step) begin
            pos_q <= pos_q + 2'h1;
        end
    end
    // Gray order: each step moves one phase only
    assign pins = {1'b0, pos_q[1] ^ pos_q[0], pos_q[1] ^ glitch_a, pos_q == 2'h0};
endmodule : encoder_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Bench for the velocity capture block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import feedback_pkg::*;
;
    // ----
    // Signals
    // ----
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sleep_mode = 1'b0;
    logic stp = 1'b0;
    logic glt = 1'b0;
    axi_req_s rq = '0;
    axi_rsp_s rs;
    enc_pins_s pins;
    enc_pins_s filt;
    logic vp;
    logic wake;
    logic [31:0] d;
    logic [31:0] v;
    logic [1:0] rr;
    int n_mismatch = 0;
    int total_checks = 0;
    int np = 0;
    int n0;
    logic [7:0] mode_t [0:5] = '{8'h94, 8'h14, 8'h15, 8'h16, 8'h17, 8'h04};
    int step_t [0:5] = '{8, 8, 8, 32, 128, 8};
    int exp_t [0:5] = '{0, 8, 2, 2, 2, 4};
    velocity_capture velocity_capture_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .bus_req(rq), .bus_rsp(rs), .pins_raw(pins), .sleep_mode(sleep_mode),
        .capture_event_in(3'h0), .position_event_in(1'b0), .direction_change_in(1'b0),
        .pins_filt(filt), .velocity_capture_pulse(vp), .wake_request(wake));
    encoder_model encoder_model_inst (.core_clk(core_clk), .sys_rst(sys_rst), .step(stp),
        .glitch_a(glt), .pins(pins));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (vp === 1'b1) np <= np + 1;
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge core_clk);
        rq.awaddr <= a;
        rq.wdata <= w;
        rq.wstrb <= 4'hf;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
            if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
            if (rs.bvalid === 1'b1) break;
        end
        rq.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
            if (rs.rvalid === 1'b1) break;
        end
        d = rs.rdata;
        rr = rs.rresp;
        rq.rready <= 1'b0;
    endtask : rd
    task automatic move(input int n);
        repeat (n) begin
            @(posedge core_clk);
            stp <= 1'b1;
            @(posedge core_clk);
            stp <= 1'b0;
            repeat (16) @(posedge core_clk);
        end
    endtask : move
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // ----
    // Tests
    // ----
    initial begin
        repeat (30000) @(posedge core_clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(OFF_FILTER);
        chk(d, 32'h0);
        wr(OFF_FILTER, 32'hff);
        rd(OFF_FILTER);
        chk(d, 32'h7f);
        rd(8'h20);
        chk(32'(rr), 32'(RESP_DECERR));
        wr(8'h20, 32'h1);
        wr(OFF_FILTER, 32'h0);
        wr(OFF_TBCTL, 32'h3);
        wr(OFF_CAP1, 32'h40);
        for (int i = 0; i < 6; i++) begin
            wr(OFF_ENC, 32'h80);
            wr(OFF_ENC, 32'(mode_t[i]));
            n0 = np;
            move(step_t[i]);
            chk(32'(np - n0), 32'(exp_t[i]));
        end
        rd(OFF_FLAGS);
        chk(d, 32'h1);
        wr(OFF_FLAGS, 32'h7);
        rd(OFF_FLAGS);
        chk(d, 32'h0);
        wr(OFF_ENC, 32'h14);
        move(1);
        rd(OFF_TIMER);
        chk(32'(d < 32'h10), 32'h1);
        wr(OFF_CAP1, 32'h0);
        move(1);
        rd(OFF_VELCAP);
        v = d;
        rd(OFF_TIMER);
        chk(32'(d > v), 32'h1);
        wr(OFF_FILTER, 32'h10);
        @(posedge core_clk);
        glt <= 1'b1;
        @(posedge core_clk);
        glt <= 1'b0;
        repeat (20) begin
            @(posedge core_clk);
            chk(32'(filt.phase_a), 32'(pins.phase_a));
        end
        move(2);
        chk(32'(filt.phase_a), 32'(pins.phase_a));
        wr(OFF_IRQEN, 32'h1);
        move(1);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(32'(wake), 32'h1);
        sleep_mode <= 1'b0;
        end_sim();
    end
endmodule : testbench
`default_nettype wire

// ==== tb/velocity_capture_asserts.sv ====
// Port checker for the velocity capture block
`timescale 1ns/1ps
`default_nettype none
module velocity_capture_asserts
    import feedback_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire axi_req_s bus_req,
    input wire axi_rsp_s bus_rsp,
    input wire logic sleep_mode,
    input wire enc_pins_s pins_filt,
    input wire logic velocity_capture_pulse,
    input wire logic wake_request
);
    // ----
    // Checks
    // ----
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd; bus_req.arvalid && bus_rsp.arready; endsequence
    sequence s_wr; bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready;
    endsequence
    property p_rd; s_rd |=> bus_rsp.rvalid && !bus_rsp.arready; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_wr; s_wr |=> ##1 bus_rsp.bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_bdone; bus_rsp.bvalid && bus_req.bready |=> !bus_rsp.bvalid; endproperty
    a_bdone: assert property (p_bdone) else $error("write answer stuck");
    property p_rdone; bus_rsp.rvalid && bus_req.rready |=> bus_rsp.arready; endproperty
    a_rdone: assert property (p_rdone) else $error("read port stuck");
    property p_top; s_rd ##0 bus_req.araddr == OFF_FILTER |=> bus_rsp.rdata[31:7] == '0;
    endproperty
    a_top: assert property (p_top) else $error("filter control top bits set");
    property p_bad; s_wr ##0 bus_req.awaddr == 8'h20 |=> ##1 bus_rsp.bresp == RESP_DECERR;
    endproperty
    a_bad: assert property (p_bad) else $error("unmapped write accepted");
    property p_wake; !sleep_mode |=> !wake_request; endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    property p_rst; $fell(sys_rst) |-> pins_filt == '0 && !velocity_capture_pulse; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule : velocity_capture_asserts
bind velocity_capture velocity_capture_asserts velocity_capture_asserts_inst (.*);
`default_nettype wire
